// [core/hbs_consts.svh]
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH
// timebase
`define HBS_CLK_HZ          25000000
`define HBS_TICK_NS         1000000
`define HBS_CLK_NS          40
`define HBS_TICK_CYC        (`HBS_TICK_NS / `HBS_CLK_NS)
// output selection code that routes the brake signal
`define HBS_SEL_BRAKE       4'h4
// setting limits and defaults
`define HBS_REL_MIN         (-2000)
`define HBS_REL_MAX         2000
`define HBS_ENG_MAX         500
`define HBS_UNIT_MS         10
`define HBS_SPD_MIN         10
`define HBS_SPD_MAX         100
`define HBS_SPD_DEF         100
`define HBS_TMO_MIN         10
`define HBS_TMO_MAX         100
`define HBS_TMO_DEF         50
`endif

// [core/hbs_pkg.sv]
package hbs_pkg;
	typedef enum logic [2:0] {
		HBS_OFF,
		HBS_ON_WAIT,
		HBS_ON,
		HBS_OFF_WAIT,
		HBS_STOP_WAIT
	} hbs_state_e;

	// brake settings as loose bits from the drive's parameter store
	typedef struct packed {
		logic [3:0][3:0] brake_output_select;
		logic [11:0]     brake_release_delay;  // signed ms
		logic [8:0]      brake_engage_delay;   // x10 ms
		logic [6:0]      brake_engage_speed_threshold; // rpm
		logic [6:0]      brake_engage_timeout; // x10 ms
	} hbs_cfg_s;

	typedef struct packed {
		hbs_state_e  st;
		logic [14:0] pre;
		logic [12:0] ms;     // wide enough for the 5000 ms engage limit
		logic        brake_control_n;
		logic        power_on;
		logic [3:0]  dout;
		logic [3:0]  dout_sel;
		logic        en_q;
	} hbs_reg_s;
endpackage

// [core/hbs_sequencer.sv]
`timescale 1ns/10ps
`include "hbs_consts.svh"
module hbs_sequencer
#(
	// clock cycles per millisecond tick
	parameter int TICK_CYC = `HBS_TICK_CYC
)
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// drive state, same clock domain
	input  wire logic              servo_on,
	input  wire logic              alarm,
	input  wire logic [15:0]       speed_rpm,
	input  wire hbs_pkg::hbs_cfg_s cfg,
	// outputs
	output logic                   motor_power,
	output logic                   brake_control_n,
	output logic [3:0]             digital_output
);
	import hbs_pkg::*;

	localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);

	hbs_reg_s r;
	hbs_reg_s n;

	logic              used;
	logic              moving;
	logic              en_now;
	logic              rel_neg;
	logic [11:0]       rel_mag;
	logic [12:0]       eng_ms;
	logic [12:0]       tmo_ms;
	logic              tick;

	always_comb
	begin
		used    = 1'b0;
		for (int i = 0; i < 4; i++)
			used = used | (cfg.brake_output_select[i] == `HBS_SEL_BRAKE);
		en_now  = servo_on & ~alarm;
		moving  = speed_rpm >= {9'h000, cfg.brake_engage_speed_threshold};
		rel_neg = cfg.brake_release_delay[11];
		rel_mag = rel_neg ? 12'(-cfg.brake_release_delay)
			: cfg.brake_release_delay;
		eng_ms  = 13'(cfg.brake_engage_delay * 4'd10);
		tmo_ms  = 13'(cfg.brake_engage_timeout * 4'd10);
		tick    = r.pre == TICK_LAST;
	end

	// one state record, one next-state process
	always_comb
	begin
		n       = r;
		n.en_q  = en_now;
		n.pre   = tick ? 15'h0000 : r.pre + 15'h0001;
		// saturate so a long wait never wraps back below a limit
		if (tick && r.ms != 13'h1fff)
			n.ms = r.ms + 13'h0001;
		case (r.st)
			HBS_OFF:
				if (en_now)
				begin
					n.ms  = 13'h0000;
					n.pre = 15'h0000;
					if (!used || rel_mag == 12'h000)
					begin
						n.brake_control_n = 1'b0;
						n.power_on        = 1'b1;
						n.st              = HBS_ON;
					end
					else if (rel_neg)
					begin
						n.power_on = 1'b1;
						n.st       = HBS_ON_WAIT;
					end
					else
					begin
						n.brake_control_n = 1'b0;
						n.st              = HBS_ON_WAIT;
					end
				end
			HBS_ON_WAIT, HBS_ON:
				if (!en_now)
				begin
					n.ms  = 13'h0000;
					n.pre = 15'h0000;
					if (!used)
					begin
						n.brake_control_n = 1'b1;
						n.power_on        = 1'b0;
						n.st              = HBS_OFF;
					end
					else if (moving)
					begin
						n.power_on = 1'b0;
						n.st       = HBS_STOP_WAIT;
					end
					else if (alarm || eng_ms == 13'h0000)
					begin
						n.brake_control_n = 1'b1;
						n.power_on        = 1'b0;
						n.st              = HBS_OFF;
					end
					else
					begin
						n.brake_control_n = 1'b1;
						n.st              = HBS_OFF_WAIT;
					end
				end
				else if (r.st == HBS_ON_WAIT && r.ms >= {1'b0, rel_mag})
				begin
					n.brake_control_n = 1'b0;
					n.power_on        = 1'b1;
					n.st              = HBS_ON;
				end
			HBS_OFF_WAIT:
				if (alarm || r.ms >= eng_ms)
				begin
					n.power_on = 1'b0;
					n.st       = HBS_OFF;
				end
			HBS_STOP_WAIT:
				if (!moving || r.ms >= tmo_ms)
				begin
					n.brake_control_n = 1'b1;
					n.st              = HBS_OFF;
				end
			default:
				n.st = HBS_OFF;
		endcase
		// route inverted brake signal, high while the brake is released, to selected outputs
		n.dout_sel = 4'h0;
		for (int i = 0; i < 4; i++)
			n.dout_sel[i] = cfg.brake_output_select[i] == `HBS_SEL_BRAKE;
		for (int i = 0; i < 4; i++)
			n.dout[i] = r.dout_sel[i] & ~n.brake_control_n;
		if (sys_rst)
		begin
			n                 = '0;
			n.st              = HBS_OFF;
			n.brake_control_n = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
		r <= n;

	assign motor_power     = r.power_on;
	assign brake_control_n = r.brake_control_n;
	assign digital_output  = r.dout;

	// engaged brake with power off is the only idle state
	AST_OFF_SAFE:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		r.st == HBS_OFF |-> brake_control_n && !motor_power)
	else $error("idle state must have brake engaged, power off");

	AST_ALARM_CUT:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		alarm && !moving && r.st == HBS_ON |=> !motor_power)
	else $error("alarm did not remove power at once");

	AST_STOP_POWER:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		r.st == HBS_STOP_WAIT |-> !motor_power && !brake_control_n)
	else $error("stopping wait must have power off, brake released");

	AST_TMO:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		r.st == HBS_STOP_WAIT && r.ms >= tmo_ms |=> r.st == HBS_OFF)
	else $error("timeout did not engage brake");

	AST_POS_ORDER:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(motor_power) && !rel_neg && rel_mag != 12'h000 && used
		|-> !$past(brake_control_n))
	else $error("power came before brake release");

	AST_ZERO:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		r.st == HBS_OFF && en_now && rel_mag == 12'h000
		|=> motor_power && !brake_control_n)
	else $error("zero delay did not switch both together");

	AST_ROUTE:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		r.dout_sel[0] && $stable(r.dout_sel[0]) && !n.brake_control_n
		|=> digital_output[0])
	else $error("brake signal not routed to output zero");

	AST_BYPASS:
	assert property (@(posedge ref_clk) disable iff (sys_rst)
		!used && r.st == HBS_OFF && en_now |=> r.st == HBS_ON)
	else $error("unused brake still sequenced");
endmodule

// [tb/hbs_relay_model.sv]
`timescale 1ns/10ps
module hbs_relay_model
#(
	parameter int DLY = 1
)
(
	// clock and coil drive
	input  wire logic ref_clk,
	input  wire logic brake_control_n,
	// contact, high while the coil holds the brake open
	output logic      coil_on
);
	logic [7:0] q;
	// pull-in lags the drive output, so checks allow a cycle of slack
	always_ff @(posedge ref_clk)
		q <= {q[6:0], ~brake_control_n};
	assign coil_on = q[DLY-1];
endmodule

// [tb/holding_brake_sequencer_test.sv]
`timescale 1ns/10ps
module holding_brake_sequencer_test;
	import hbs_pkg::*;
	typedef struct packed
	{
		logic        son;
		logic        alm;
		logic [15:0] spd;
		logic [11:0] rel;
		logic [15:0] sel;
		logic [15:0] w;
		logic [6:0]  exp;
	} hbs_row_s;
	logic      ref_clk;
	logic      sys_rst;
	logic      servo_on;
	logic      alarm;
	logic      motor_power;
	logic      brake_control_n;
	logic      coil_on;
	logic [15:0] speed_rpm;
	logic [3:0] digital_output;
	hbs_cfg_s  cfg;
	int        err_count = 0;
	int        compares = 0;
	int        cyc = 0;
	// expected: power, brake_n, outputs, coil
	hbs_row_s rows [12] = '{
		'{1'h1,1'h0,16'h0,12'h0,16'h4000,16'h3,7'h51},
		'{1'h0,1'h0,16'h0,12'h0,16'h4000,16'h3,7'h20},
		'{1'h1,1'h0,16'h0,12'h1,16'h0,16'h3,7'h41},
		'{1'h0,1'h0,16'h0,12'h1,16'h0004,16'h3,7'h20},
		'{1'h1,1'h0,16'h0,12'h1,16'h0004,16'h3,7'h03},
		'{1'h1,1'h0,16'h0,12'h1,16'h0004,16'h0028,7'h43},
		'{1'h0,1'h0,16'h0,12'hfff,16'h0004,16'h3,7'h20},
		'{1'h1,1'h0,16'h0,12'hfff,16'h0004,16'h3,7'h60},
		'{1'h1,1'h0,16'h0,12'hfff,16'h0004,16'h0028,7'h43},
		'{1'h1,1'h1,16'h0,12'h0,16'h0040,16'h3,7'h20},
		'{1'h1,1'h0,16'h0,12'h0,16'h0040,16'h3,7'h45},
		'{1'h0,1'h0,16'hc8,12'h0,16'h0040,16'h3,7'h05}
	};
	// short tick keeps the 10 ms delays within the run budget
	hbs_sequencer #(.TICK_CYC(25)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.servo_on(servo_on), .alarm(alarm), .speed_rpm(speed_rpm),
		.cfg(cfg), .motor_power(motor_power),
		.brake_control_n(brake_control_n),
		.digital_output(digital_output));
	hbs_relay_model relay (.ref_clk(ref_clk),
		.brake_control_n(brake_control_n), .coil_on(coil_on));
	// one mismatch line per failing compare
	task automatic cmp(input logic [6:0] exp);
		compares++;
		if ({motor_power, brake_control_n, digital_output, coil_on} !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t outputs differ, expected %h", $time, exp);
		end
	endtask
	task automatic print_verdict;
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// free-running 25 MHz clock
	initial
	begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	// hang guard, well above the timeout scenario
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			print_verdict();
		end
	end
	// table first, then stationary engage delay stop, moving stop above threshold and mid-run reset
	initial
	begin
		sys_rst = 1'h1;
		servo_on = 1'h0;
		alarm = 1'h0;
		speed_rpm = 16'h0;
		cfg = {16'h0, 12'h0, 9'h0, 7'h64, 7'h32};
		repeat (16) @(posedge ref_clk);
		#1;
		cmp(7'h20);
		sys_rst = 1'h0;
		foreach (rows[i])
		begin
			@(posedge ref_clk);
			#1;
			servo_on = rows[i].son;
			alarm = rows[i].alm;
			speed_rpm = rows[i].spd;
			cfg.brake_release_delay = rows[i].rel;
			cfg.brake_output_select = rows[i].sel;
			repeat (rows[i].w) @(posedge ref_clk);
			#1;
			cmp(rows[i].exp);
		end
		speed_rpm = 16'h32;
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(7'h20);
		// stationary disable with a 10 ms engage delay
		cfg.brake_engage_delay = 9'h001;
		servo_on = 1'h1;
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(7'h45);
		servo_on = 1'h0;
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(7'h60);
		repeat (240) @(posedge ref_clk);
		#1;
		cmp(7'h60);
		repeat (20) @(posedge ref_clk);
		#1;
		cmp(7'h20);
		// moving stop that ends on the 100 ms timeout
		cfg.brake_engage_delay = 9'h000;
		cfg.brake_engage_timeout = 7'h0a;
		servo_on = 1'h1;
		// host holds motion back 50 ms plus release time
		repeat (1300) @(posedge ref_clk);
		#1;
		cmp(7'h45);
		speed_rpm = 16'hc8;
		servo_on = 1'h0;
		repeat (3) @(posedge ref_clk);
		#1;
		cmp(7'h05);
		repeat (2400) @(posedge ref_clk);
		#1;
		cmp(7'h05);
		repeat (110) @(posedge ref_clk);
		#1;
		cmp(7'h20);
		speed_rpm = 16'h0;
		servo_on = 1'h1;
		repeat (3) @(posedge ref_clk);
		#1;
		sys_rst = 1'h1;
		repeat (2) @(posedge ref_clk);
		#1;
		cmp(7'h20);
		print_verdict();
	end
endmodule
